// ==== design/fsf_regs.vh ====
// Register map, field positions and timing constants of the flash status flag block
`ifndef FSF_REGS_VH
`define FSF_REGS_VH
// Byte offsets on the register bus
`define FSF_CTRL_OFF      8'h00
`define FSF_STATUS_OFF    8'h04
`define FSF_PDATA_OFF     8'h08
`define FSF_CELL_OFF      8'h0c
`define FSF_READ_OFF      8'h10
`define FSF_BOOT_OFF      8'h14
`define FSF_LIMIT_OFF     8'h18
// Control register command bits (write one to act)
`define FSF_CMD_PROG      0
`define FSF_CMD_CHIP      1
`define FSF_CMD_BLOCK     2
`define FSF_CMD_RESET     3
`define FSF_CMD_FAIL      4
`define FSF_CMD_DONE      5
// Status read positions
`define FSF_ERASE_WIN     3
`define FSF_TIMEOUT       5
`define FSF_TOGGLE        6
`define FSF_POLL          7
// Status register fields
`define FSF_ST_BUSY       0
`define FSF_ST_HOLD       1
`define FSF_ST_FAILED     2
`define FSF_ST_ERASE      3
`define FSF_ST_SBOOT      4
// Reset values
`define FSF_CELL_RST      16'hffff
`define FSF_LIMIT_RST     32'h000f4240
// Erase hold window in microseconds and clock rate in MHz
`define FSF_HOLD_US       80
`define FSF_CLK_MHZ       200
`define FSF_HOLD_CYC      (`FSF_HOLD_US * `FSF_CLK_MHZ)
`endif

// ==== design/fsf_sync.v ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fsf_sync #(
  parameter WIDTH = 3
) (
  // Clocking
  input  wire             clk,
  input  wire             ce,
  // Data
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always @(posedge clk)
  begin
    if (ce)
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // fsf_sync

// ==== design/fsf_flags.v ====
// Flash sequencer status flags, erase hold window and single-boot strap capture
//
// Function
// [RULE_01] Polling starts after last command write
// [RULE_02] Program: inverted bit 7, then cell
// [RULE_03] Erase: bit 7 zero, then one
// [RULE_04] Failure keeps in-progress bit 7 value
// [RULE_05] Poller reads programmed or erased address
// [RULE_06] Bit 6 inverts every status read
// [RULE_07] Success stops toggle, returns cell bit
// [RULE_08] Failure keeps bit 6 toggling
// [RULE_09] Bit 5 one after time limit
// [RULE_10] Bit 5 one on zero-to-one program
// [RULE_11] Failure locks until reset command
// [RULE_12] Block erase starts after 80 us hold
// [RULE_13] Bit 3 zero in hold, one erasing
// [RULE_14] Each block command restarts hold count
// [RULE_15] Failure returns one on bit 3
// [RULE_16] No ready/busy output to processor
// [RULE_17] Rewrite code runs outside the array
// [RULE_18] Interrupts disabled before rewrite
// [RULE_19] Single boot remaps boot ROM, array
// [RULE_20] Mode pins sampled at reset release
// [RULE_21] Bits 15..8 and 2..0 undefined
// [RULE_22] Counters count clocks, cleared by resets
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fsf_regs.vh"
module fsf_flags #(
  parameter HOLD_CYC = `FSF_HOLD_CYC,
  parameter ADDR_W   = 8
) (
  // Clock, reset, enable
  input  wire              CORE_CLK,
  input  wire              RESET,
  input  wire              CE,
  // Strap pins
  input  wire              MODE_SELECT_PIN0,
  input  wire              MODE_SELECT_PIN1,
  input  wire              BOOT_SELECT_N,
  // Mapping outputs
  output wire              SINGLE_BOOT,
  output wire              BOOT_ROM_AT_VECTORS,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire              S_AXI_AWVALID,
  output wire              S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire [31:0]       S_AXI_WDATA,
  input  wire [3:0]        S_AXI_WSTRB,
  input  wire              S_AXI_WVALID,
  output wire              S_AXI_WREADY,
  // AXI4-Lite write response
  output reg  [1:0]        S_AXI_BRESP,
  output reg               S_AXI_BVALID,
  input  wire              S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire              S_AXI_ARVALID,
  output wire              S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg  [31:0]       S_AXI_RDATA,
  output reg  [1:0]        S_AXI_RRESP,
  output reg               S_AXI_RVALID,
  input  wire              S_AXI_RREADY
);
  // Sequencer states, one-hot
  localparam [4:0] ST_READ  = 5'h01;
  localparam [4:0] ST_PROG  = 5'h02;
  localparam [4:0] ST_HOLD  = 5'h04;
  localparam [4:0] ST_ERASE = 5'h08;
  localparam [4:0] ST_FAIL  = 5'h10;

  reg  [4:0]        state_reg;
  reg  [4:0]        state_next;
  reg               is_erase_reg;
  reg  [15:0]       pdata_reg;
  reg  [15:0]       cell_reg;
  reg               toggle_reg;
  reg               tmo_reg;
  reg  [31:0]       hold_cnt_reg;
  reg  [31:0]       limit_reg;
  reg  [31:0]       run_cnt_reg;
  reg               sboot_reg;
  reg               strap_armed_reg;
  reg  [ADDR_W-1:0] awaddr_reg;
  reg               aw_full_reg;
  reg  [31:0]       wdata_reg;
  reg  [3:0]        wstrb_reg;
  reg               w_full_reg;
  wire [2:0]        pins_sync;
  wire              wr_go;
  wire              rd_go;
  wire [31:0]       cmd;
  reg  [15:0]       status_word;
  reg  [31:0]       rd_mux;
  reg               rd_ok;
  reg               wr_ok;

  // Strap pins come from outside the clock domain
  fsf_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk (CORE_CLK),
    .ce  (CE),
    .d   ({MODE_SELECT_PIN0, MODE_SELECT_PIN1, BOOT_SELECT_N}),
    .q   (pins_sync)
  );

  // Write channels taken independently, one write in flight
  // Readies drop with the enable, so nothing is taken while state is frozen
  assign S_AXI_AWREADY = CE & ~aw_full_reg & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = CE & ~w_full_reg & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = CE & ~S_AXI_RVALID;
  assign wr_go         = aw_full_reg & w_full_reg & ~S_AXI_BVALID;
  assign rd_go         = S_AXI_ARVALID & ~S_AXI_RVALID;
  assign cmd           = (wr_go && awaddr_reg[ADDR_W-1:2] == `FSF_CTRL_OFF >> 2 && wstrb_reg[0]) ? wdata_reg : 32'h0;

  // Mapping follows the strap; boot ROM covers vector area in single boot
  assign SINGLE_BOOT         = sboot_reg;
  assign BOOT_ROM_AT_VECTORS = sboot_reg; // RULE_19

  // Status word; undefined bits read as zero, reads outside automatic mode give cell data
  always @*
  begin
    status_word = 16'h0000; // RULE_21
    if (state_reg == ST_READ)
      status_word = cell_reg; // RULE_07
    else
    begin
      status_word[`FSF_POLL]      = is_erase_reg ? 1'b0 : ~pdata_reg[`FSF_POLL]; // RULE_01 RULE_02 RULE_03 RULE_04
      status_word[`FSF_TOGGLE]    = toggle_reg; // RULE_06 RULE_08
      status_word[`FSF_TIMEOUT]   = tmo_reg; // RULE_09 RULE_10
      status_word[`FSF_ERASE_WIN] = (state_reg == ST_ERASE) | (state_reg == ST_FAIL); // RULE_13 RULE_15
    end
  end

  // Read decode; no ready/busy pin, but status register bit 0 shows busy beside the flag word
  always @*
  begin
    rd_mux = 32'h0;
    rd_ok  = 1'b1;
    case (S_AXI_ARADDR[ADDR_W-1:2])
      `FSF_CTRL_OFF >> 2:   rd_mux = 32'h0;
      `FSF_STATUS_OFF >> 2: rd_mux = {27'h0, sboot_reg, state_reg == ST_ERASE, state_reg == ST_FAIL,
                                      state_reg == ST_HOLD, state_reg != ST_READ};
      `FSF_PDATA_OFF >> 2:  rd_mux = {16'h0, pdata_reg};
      `FSF_CELL_OFF >> 2:   rd_mux = {16'h0, cell_reg};
      `FSF_READ_OFF >> 2:   rd_mux = {16'h0, status_word}; // RULE_16
      `FSF_BOOT_OFF >> 2:   rd_mux = {31'h0, sboot_reg};
      `FSF_LIMIT_OFF >> 2:  rd_mux = limit_reg;
      default:              rd_ok  = 1'b0;
    endcase
  end

  // Write address decode for the response code
  always @*
  begin
    case (awaddr_reg[ADDR_W-1:2])
      `FSF_CTRL_OFF >> 2, `FSF_PDATA_OFF >> 2, `FSF_CELL_OFF >> 2, `FSF_LIMIT_OFF >> 2,
      `FSF_STATUS_OFF >> 2, `FSF_READ_OFF >> 2, `FSF_BOOT_OFF >> 2: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Sequencer next state; reset command overrides everything, failure beats done while programming or erasing
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_READ:
      begin
        if (cmd[`FSF_CMD_PROG])
          state_next = ST_PROG;
        else if (cmd[`FSF_CMD_CHIP])
          state_next = ST_ERASE;
        else if (cmd[`FSF_CMD_BLOCK])
          state_next = ST_HOLD;
      end
      ST_PROG, ST_ERASE:
      begin
        if (tmo_reg || cmd[`FSF_CMD_FAIL] || run_cnt_reg >= limit_reg)
          state_next = ST_FAIL;
        else if (cmd[`FSF_CMD_DONE])
          state_next = ST_READ; // RULE_07
      end
      ST_HOLD:
      begin
        // A block command on the last window cycle still restarts the window
        if (cmd[`FSF_CMD_BLOCK])
          state_next = ST_HOLD; // RULE_14
        else if (hold_cnt_reg >= HOLD_CYC - 1)
          state_next = ST_ERASE; // RULE_12
        else if (|cmd[`FSF_CMD_CHIP:`FSF_CMD_PROG])
          state_next = ST_READ; // Program or chip erase command in the window aborts
      end
      ST_FAIL:
        state_next = ST_FAIL; // RULE_11
      default:
        state_next = ST_READ;
    endcase
    if (cmd[`FSF_CMD_RESET])
      state_next = ST_READ; // RULE_11
  end

  // Bus slave and sequencer registers
  always @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      state_reg       <= ST_READ;
      is_erase_reg    <= 1'b0;
      pdata_reg       <= 16'h0000;
      cell_reg        <= `FSF_CELL_RST;
      toggle_reg      <= 1'b0;
      tmo_reg         <= 1'b0;
      hold_cnt_reg    <= 32'h0;
      run_cnt_reg     <= 32'h0;
      limit_reg       <= `FSF_LIMIT_RST;
      sboot_reg       <= 1'b0;
      strap_armed_reg <= 1'b1;
      aw_full_reg     <= 1'b0;
      w_full_reg      <= 1'b0;
      awaddr_reg      <= {ADDR_W{1'b0}};
      wdata_reg       <= 32'h0;
      wstrb_reg       <= 4'h0;
      S_AXI_BVALID    <= 1'b0;
      S_AXI_BRESP     <= 2'h0;
      S_AXI_RVALID    <= 1'b0;
      S_AXI_RRESP     <= 2'h0;
      S_AXI_RDATA     <= 32'h0;
    end
    else if (CE)
    begin
      // Strap caught once, at the first enabled cycle after release, from what the synchroniser took during reset
      if (strap_armed_reg)
      begin
        strap_armed_reg <= 1'b0;
        sboot_reg       <= pins_sync[2] & pins_sync[1] & ~pins_sync[0]; // RULE_20
      end
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        awaddr_reg  <= S_AXI_AWADDR;
        aw_full_reg <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        wdata_reg  <= S_AXI_WDATA;
        wstrb_reg  <= S_AXI_WSTRB;
        w_full_reg <= 1'b1;
      end
      if (wr_go)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? 2'h0 : 2'h2;
        // Program data register only loads while the array is idle; cell and limit load at any time
        if (state_reg == ST_READ && awaddr_reg[ADDR_W-1:2] == `FSF_PDATA_OFF >> 2 && wstrb_reg[1:0] == 2'h3)
          pdata_reg <= wdata_reg[15:0];
        if (awaddr_reg[ADDR_W-1:2] == `FSF_CELL_OFF >> 2 && wstrb_reg[1:0] == 2'h3)
          cell_reg <= wdata_reg[15:0];
        if (awaddr_reg[ADDR_W-1:2] == `FSF_LIMIT_OFF >> 2 && wstrb_reg == 4'hf)
          limit_reg <= wdata_reg;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (rd_go)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_mux;
        S_AXI_RRESP  <= rd_ok ? 2'h0 : 2'h2;
        // Each flag read inverts the toggle bit while automatic
        if (state_reg != ST_READ && S_AXI_ARADDR[ADDR_W-1:2] == `FSF_READ_OFF >> 2)
          toggle_reg <= ~toggle_reg; // RULE_06 RULE_08
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
      state_reg <= state_next;
      // Entry into automatic mode from read
      if (state_reg == ST_READ && state_next != ST_READ)
      begin
        is_erase_reg <= ~cmd[`FSF_CMD_PROG];
        toggle_reg   <= 1'b1; // RULE_06
        // Zero cell asked to become one cannot be programmed
        tmo_reg      <= cmd[`FSF_CMD_PROG] & |(pdata_reg & ~cell_reg); // RULE_10
      end
      // Any failure of a running operation reads as timed out
      else if ((state_reg == ST_PROG || state_reg == ST_ERASE) && state_next == ST_FAIL)
        tmo_reg <= 1'b1; // RULE_09
      // Time limit counter runs only while working
      if (state_reg == ST_PROG || state_reg == ST_ERASE)
        run_cnt_reg <= run_cnt_reg + 32'h1; // RULE_22
      else
        run_cnt_reg <= 32'h0;
      // Hold window counts cycles, restarting on each block command
      if (state_reg != ST_HOLD || cmd[`FSF_CMD_BLOCK] || cmd[`FSF_CMD_RESET])
        hold_cnt_reg <= 32'h0; // RULE_14 RULE_22
      else
        hold_cnt_reg <= hold_cnt_reg + 32'h1; // RULE_12
      if (state_next == ST_READ && state_reg != ST_READ)
      begin
        tmo_reg <= 1'b0;
        // Only a finished erase sets the cells; an abandoned window leaves them
        if (state_reg == ST_ERASE && !cmd[`FSF_CMD_RESET])
          cell_reg <= 16'hffff; // RULE_03
        else if (state_reg == ST_PROG && !cmd[`FSF_CMD_RESET])
          cell_reg <= cell_reg & pdata_reg; // RULE_02
      end
    end
  end
endmodule // fsf_flags

// ==== tb/fsf_flags_monitor.sv ====
// Assertions on the read handshake and strap ports of the flag block
`timescale 1ns/1ps
module fsf_flags_monitor (
  // Clock and reset
  input wire CORE_CLK,
  input wire RESET,
  // Straps and mapping
  input wire MODE_SELECT_PIN0,
  input wire MODE_SELECT_PIN1,
  input wire BOOT_SELECT_N,
  input wire SINGLE_BOOT,
  input wire BOOT_ROM_AT_VECTORS,
  // Read channels
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  default clocking dc @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);
  // Address taken at one edge, answer due at the next
  sequence rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  rd_answer_a: assert property (rd_taken |=> S_AXI_RVALID) else $error("read not answered");
  rd_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("address taken while busy");
  rd_once_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("answer repeated");
  rd_quiet_a: assert property (!S_AXI_RVALID && !S_AXI_ARVALID |=> !S_AXI_RVALID) else $error("unasked answer");
  // Own disable: rst_clear_a watches the reset itself
  rst_clear_a: assert property (disable iff (1'b0) RESET |=> !S_AXI_RVALID && !SINGLE_BOOT)
    else $error("reset left state");
  boot_map_a: assert property (SINGLE_BOOT == BOOT_ROM_AT_VECTORS) else $error("boot map split");
  boot_take_a: assert property ($fell(RESET) |=>
    SINGLE_BOOT == (MODE_SELECT_PIN0 && MODE_SELECT_PIN1 && !BOOT_SELECT_N)) else $error("strap not taken");
  boot_hold_a: assert property (!$past(RESET) && !$past(RESET, 2) |-> $stable(SINGLE_BOOT))
    else $error("strap moved after release");
endmodule // fsf_flags_monitor
bind fsf_flags fsf_flags_monitor i_mon (.CORE_CLK(CORE_CLK), .RESET(RESET), .MODE_SELECT_PIN0(MODE_SELECT_PIN0),
  .MODE_SELECT_PIN1(MODE_SELECT_PIN1), .BOOT_SELECT_N(BOOT_SELECT_N), .SINGLE_BOOT(SINGLE_BOOT),
  .BOOT_ROM_AT_VECTORS(BOOT_ROM_AT_VECTORS), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// ==== tb/fsf_cpu.sv ====
// Processor-side bus master that issues flash commands and polls flags
`timescale 1ns/1ps
module fsf_cpu (
  // Clock and write channels
  input  wire         clk,
  output logic [7:0]  awaddr,
  output logic        awvalid,
  input  wire         awready,
  output logic [31:0] wdata,
  output logic        wvalid,
  input  wire         wready,
  input  wire  [1:0]  bresp,
  input  wire         bvalid,
  output logic        bready,
  // Read channels
  output logic [7:0]  araddr,
  output logic        arvalid,
  input  wire         arready,
  input  wire  [31:0] rdata,
  input  wire  [1:0]  rresp,
  input  wire         rvalid,
  output logic        rready
);
  // Idle bus from time zero; bench code lives outside the array, no interrupt path
  initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
  // Readies sampled mid-cycle: they only move at rising edges, so no race
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tk;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      tk = bvalid;
      r  = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (!tk);
    bready <= 1'b0;
  endtask
  // Flags are polled at the word of the running operation
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tk;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(negedge clk);
      ta = arready;
      tk = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    while (!tk);
    rready <= 1'b0;
  endtask
endmodule // fsf_cpu

// ==== tb/tb.sv ====
// Bench: command sequences against the flag block, flags polled over the bus
`timescale 1ns/1ps
`include "fsf_regs.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module tb;
  localparam int HOLD = 20;
  localparam logic [7:0] FW = `FSF_READ_OFF;
  logic        clk, rst, ce, ms0, ms1, bsel_n, sb, rom;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int          n_fail, samples_checked;
  // Short hold window keeps the run brief
  fsf_flags #(.HOLD_CYC(HOLD)) i_dut (.CORE_CLK(clk), .RESET(rst), .CE(ce),
    .MODE_SELECT_PIN0(ms0), .MODE_SELECT_PIN1(ms1), .BOOT_SELECT_N(bsel_n), .SINGLE_BOOT(sb),
    .BOOT_ROM_AT_VECTORS(rom), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  // Processor model on the far side
  fsf_cpu i_cpu (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Straps settle well before release so the synchroniser has caught up
  task automatic rst_pins(input logic [2:0] p);
    @(posedge clk);
    {ms0, ms1, bsel_n} <= p;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_cpu.wr(a, d, r);
    `CHK("write resp", 2'h0, r)
  endtask
  task automatic cmd(input int b);
    wr(`FSF_CTRL_OFF, 32'h1 << b);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    i_cpu.rd(a, d, r);
    `CHK(n, e, d)
    `CHK("read resp", 2'h0, r)
  endtask
  task automatic t_regs;
    logic [1:0]  r;
    logic [31:0] d;
    chk(`FSF_CELL_OFF, 32'h0000ffff, "cell reset");
    chk(`FSF_LIMIT_OFF, 32'h000f4240, "limit reset");
    chk(FW, 32'h0000ffff, "read mode word");
    i_cpu.wr(8'h1c, 32'h0, r);
    `CHK("unmapped resp", 2'h2, r)
    i_cpu.rd(8'h1c, d, r);
    `CHK("unmapped rresp", 2'h2, r)
    `CHK("unmapped rdata", 32'h0, d)
  endtask
  task automatic t_prog;
    wr(`FSF_LIMIT_OFF, 32'h00000032);
    wr(`FSF_PDATA_OFF, 32'h00001234);
    cmd(`FSF_CMD_PROG);
    chk(FW, 32'h000000c0, "prog flags");
    chk(FW, 32'h00000080, "prog toggle");
    cmd(`FSF_CMD_DONE);
    chk(FW, 32'h00001234, "prog result");
  endtask
  // Setting a cleared cell fails at once and locks
  task automatic t_fail;
    wr(`FSF_PDATA_OFF, 32'h000000ff);
    cmd(`FSF_CMD_PROG);
    chk(FW, 32'h00000068, "bad prog flags");
    cmd(`FSF_CMD_DONE);
    chk(FW, 32'h00000028, "locked flags");
    cmd(`FSF_CMD_RESET);
    chk(FW, 32'h00001234, "after reset cmd");
  endtask
  task automatic t_erase;
    cmd(`FSF_CMD_CHIP);
    chk(FW, 32'h00000048, "erase flags");
    repeat (60) @(posedge clk);
    chk(FW, 32'h00000028, "erase timeout");
    cmd(`FSF_CMD_RESET);
  endtask
  // Second block inside the window pushes the erase start out
  task automatic t_block;
    wr(`FSF_LIMIT_OFF, 32'h000003e8);
    cmd(`FSF_CMD_BLOCK);
    chk(FW, 32'h00000040, "hold flags");
    repeat (HOLD - 12) @(posedge clk);
    cmd(`FSF_CMD_BLOCK);
    repeat (HOLD / 2) @(posedge clk);
    chk(FW, 32'h00000000, "hold restarted");
    repeat (HOLD + 10) @(posedge clk);
    chk(FW, 32'h00000048, "erasing flags");
    cmd(`FSF_CMD_DONE);
    chk(FW, 32'h0000ffff, "erase result");
  endtask
  // Enable low freezes the hold window count
  task automatic t_ce;
    cmd(`FSF_CMD_BLOCK);
    ce <= 1'b0;
    repeat (2 * HOLD) @(posedge clk);
    ce <= 1'b1;
    chk(FW, 32'h00000040, "frozen hold");
    cmd(`FSF_CMD_RESET);
    chk(FW, 32'h0000ffff, "hold abandoned");
  endtask
  // Forced failure of an erase locks with the timeout flag up
  task automatic t_force;
    cmd(`FSF_CMD_CHIP);
    cmd(`FSF_CMD_FAIL);
    chk(FW, 32'h00000068, "forced fail flags");
    chk(`FSF_STATUS_OFF, 32'h00000005, "failed status");
    cmd(`FSF_CMD_DONE);
    chk(FW, 32'h00000028, "forced fail locked");
    cmd(`FSF_CMD_RESET);
  endtask
  // Single boot strap and each one-pin change from it, the first one cutting a running erase
  task automatic t_boot;
    logic [2:0] p;
    cmd(`FSF_CMD_CHIP);
    for (int i = 0; i < 4; i++)
    begin
      p = (i == 0) ? 3'b110 : 3'b110 ^ (3'b001 << (i - 1));
      rst_pins(p);
      `CHK("boot pin", p == 3'b110, sb)
      `CHK("rom map", p == 3'b110, rom)
      chk(`FSF_BOOT_OFF, {31'h0, p == 3'b110}, "boot word");
      chk(FW, 32'h0000ffff, "word after reset");
    end
  endtask
  // Watchdog far beyond the few hundred cycles needed
  initial
  begin
    #20us;
    n_fail++;
    results();
  end
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    {ms0, ms1, bsel_n} = 3'b111;
    n_fail = 0;
    samples_checked = 0;
    rst_pins(3'b111);
    t_regs();
    t_prog();
    t_fail();
    t_erase();
    t_block();
    t_ce();
    t_force();
    t_boot();
    results();
  end
endmodule // tb
